// >>> common/csh_pkg.sv
package csh_pkg;
  localparam int ADDR_W_DEF = 32;
  localparam int LINE_LSB_DEF = 5;
  localparam int VEC_W = 8;
  localparam logic [31:0] RESET_VECTOR = 32'hFFFF_FFF0;
  localparam logic HIT_IDLE_N = 1'h1;
  localparam logic TRISTATE_RST = 1'h0;

  typedef enum logic [2:0] {
    CYC_FLUSH_ACK = 3'h1,
    CYC_INTA = 3'h2,
    CYC_WRITEBACK = 3'h4
  } csh_cyc_t;

  typedef enum logic {
    UPD_SHARED = 1'h0,
    UPD_INVALID = 1'h1
  } csh_line_upd_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_FLUSH_CACHE = 6'h02,
    ST_FLUSH_CYC = 6'h04,
    ST_INTA1 = 6'h08,
    ST_INTA2 = 6'h10,
    ST_WB = 6'h20
  } csh_st_t;

  typedef enum logic [3:0] {
    HS_IDLE = 4'h1,
    HS_WAIT = 4'h2,
    HS_FLOAT = 4'h4,
    HS_ACK = 4'h8
  } csh_hold_st_t;
endpackage

// >>> rtl/csh_snoop_unit.sv
`timescale 1ns/1ns
module csh_snoop_unit #(
  parameter int ADDR_W = csh_pkg::ADDR_W_DEF,
  parameter int LINE_LSB = csh_pkg::LINE_LSB_DEF
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic snoop_addr_strobe_n_in,
  input wire logic [ADDR_W-1:LINE_LSB] snoop_addr_in,
  input wire logic snoop_invalidate_in,
  input wire logic probe_hit_in,
  input wire logic probe_modified_in,
  input wire logic wb_done_in,
  output logic probe_req_out,
  output logic [ADDR_W-1:LINE_LSB] probe_addr_out,
  output logic line_update_out,
  output csh_pkg::csh_line_upd_t line_update_state_out,
  output logic snoop_hit_n_out,
  output logic snoop_hit_modified_n_out,
  output logic wb_req_out
);
  import csh_pkg::*;

  if (LINE_LSB < 3 || LINE_LSB >= ADDR_W) begin : g_param_check
    $error("csh_snoop_unit: unsupported address or line width");
  end

  logic inv_r;
  logic wb_pend_r;

  // A new inquire is ignored while a hit-modified writeback is owed
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      probe_req_out <= 1'h0;
      probe_addr_out <= '0;
      inv_r <= 1'h0;
    end else begin
      probe_req_out <= !snoop_addr_strobe_n_in && !wb_pend_r && !probe_req_out;
      if (!snoop_addr_strobe_n_in && !wb_pend_r && !probe_req_out) begin
        probe_addr_out <= snoop_addr_in;
        inv_r <= snoop_invalidate_in; // see R15
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      snoop_hit_n_out <= HIT_IDLE_N;
      snoop_hit_modified_n_out <= HIT_IDLE_N;
      line_update_out <= 1'h0;
      line_update_state_out <= UPD_SHARED;
      wb_pend_r <= 1'h0;
    end else begin
      line_update_out <= probe_req_out && probe_hit_in;
      if (probe_req_out) begin
        snoop_hit_n_out <= !probe_hit_in; // see R3
        snoop_hit_modified_n_out <= !(probe_hit_in && probe_modified_in); // see R4
        line_update_state_out <= inv_r ? UPD_INVALID : UPD_SHARED; // see R15
        wb_pend_r <= probe_hit_in && probe_modified_in; // see R5
      end else if (wb_done_in) begin
        snoop_hit_modified_n_out <= HIT_IDLE_N; // see R17
        wb_pend_r <= 1'h0;
      end
    end
  end

  assign wb_req_out = wb_pend_r;

  a_hit_follows_probe: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see R3
    probe_req_out |=> (snoop_hit_n_out == !$past(probe_hit_in)))
    else $error("hit output does not match probe result");
  a_snoop_hit_modified_n_owes_wb: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see R5
    (probe_req_out && probe_hit_in && probe_modified_in) |=> (!snoop_hit_modified_n_out && wb_req_out))
    else $error("modified hit without writeback request");
  a_idle_outputs_high: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see R17
    (probe_req_out && !probe_hit_in) |=> (snoop_hit_n_out && snoop_hit_modified_n_out))
    else $error("hit outputs low after a miss");
  a_inv_state: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see R15
    (!snoop_addr_strobe_n_in && !wb_pend_r && !probe_req_out) ##1 probe_hit_in
      |=> line_update_out && (line_update_state_out == ($past(snoop_invalidate_in, 2) ? UPD_INVALID : UPD_SHARED)))
    else $error("line update state does not follow invalidate level");
endmodule

// >>> rtl/csh_hold_arb.sv
`timescale 1ns/1ns
module csh_hold_arb (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic bus_hold_req_in,
  input wire logic cycle_active_in,
  output logic hold_pending_out,
  output logic bus_float_out,
  output logic bus_hold_ack_out
);
  import csh_pkg::*;

  csh_hold_st_t st_r;
  csh_hold_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      HS_IDLE: if (bus_hold_req_in) st_nxt = HS_WAIT;
      HS_WAIT: if (!cycle_active_in) st_nxt = HS_FLOAT; // see R7
      HS_FLOAT: st_nxt = HS_ACK;
      HS_ACK: if (!bus_hold_req_in) st_nxt = HS_IDLE; // see R16
      default: st_nxt = HS_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_r <= HS_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Float one edge ahead of the acknowledge so the bus is released first
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      bus_float_out <= 1'h0;
      bus_hold_ack_out <= 1'h0;
    end else begin
      bus_float_out <= (st_nxt == HS_FLOAT) || (st_nxt == HS_ACK); // see R8
      bus_hold_ack_out <= (st_nxt == HS_ACK); // see R7
    end
  end

  assign hold_pending_out = bus_hold_req_in || (st_r != HS_IDLE);

  a_ack_after_float: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see R7
    $rose(bus_hold_ack_out) |-> $past(bus_float_out) && !$past(cycle_active_in, 2))
    else $error("hold acknowledge before bus floated");
  a_ack_held: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see R16
    (bus_hold_ack_out && bus_hold_req_in) |=> bus_hold_ack_out)
    else $error("hold acknowledge dropped while request stands");
  a_ack_released: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see R16
    (bus_hold_ack_out && !bus_hold_req_in) |=> !bus_hold_ack_out && !bus_float_out)
    else $error("hold acknowledge kept after request removed");
endmodule

// >>> rtl/csh_sys_ctrl.sv
// Contract
// R1: Sampled flush request writes back modified lines, invalidates all, runs flush-acknowledge cycle.
// R2: Flush request level at reset release selects tri-state test mode.
// R3: Inquire hit on a valid line drives snoop hit low.
// R4: Inquire hit on a modified line drives hit-modified low.
// R5: A hit-modified inquire is followed by a writeback bus cycle for that line.
// R6: System logic requests bus ownership by raising hold request.
// R7: On hold request finish current cycles, float bus, then raise hold acknowledge.
// R8: While acknowledged, address, data, strobes, enables, parity and cycle-type outputs float.
// R9: Ignore-error input low lets a permitted unmasked floating-point exception be ignored.
// R10: Soft init flushes pipelines, reinitialises state, fetches from the reset vector.
// R11: Soft init keeps caches, floating-point, register files and cache-control bits.
// R12: Recognised interrupt runs two acknowledge cycles, then vectors by returned number.
// R13: The interrupt request is honoured only while software enables interrupts.
// R14: System logic starts an inquire with address strobe and a valid snoop address.
// R15: Invalidate level chooses invalid or shared state for the snooped line.
// R16: Hold acknowledge stays while request stands, drops and bus resumes after removal.
// R17: Hit outputs stay high when no inquire hit is reported.
`timescale 1ns/1ns
module csh_sys_ctrl #(
  parameter int ADDR_W = csh_pkg::ADDR_W_DEF,
  parameter int LINE_LSB = csh_pkg::LINE_LSB_DEF
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic flush_req_n_in,
  input wire logic snoop_addr_strobe_n_in,
  input wire logic [ADDR_W-1:LINE_LSB] snoop_addr_in,
  input wire logic snoop_invalidate_in,
  input wire logic bus_hold_req_in,
  input wire logic ignore_fp_error_n_in,
  input wire logic soft_init_in,
  input wire logic maskable_irq_in,
  input wire logic core_bus_busy_in,
  input wire logic irq_enable_in,
  input wire logic fp_exception_in,
  input wire logic fp_native_mode_in,
  input wire logic probe_hit_in,
  input wire logic probe_modified_in,
  input wire logic cache_flush_done_in,
  input wire logic bus_cyc_done_in,
  input wire logic [csh_pkg::VEC_W-1:0] bus_cyc_data_in,
  output logic snoop_hit_n_out,
  output logic snoop_hit_modified_n_out,
  output logic bus_hold_ack_out,
  output logic bus_drive_en_out,
  output logic tristate_test_mode_out,
  output logic probe_req_out,
  output logic [ADDR_W-1:LINE_LSB] probe_addr_out,
  output logic line_update_out,
  output csh_pkg::csh_line_upd_t line_update_state_out,
  output logic cache_flush_start_out,
  output logic bus_cyc_req_out,
  output csh_pkg::csh_cyc_t bus_cyc_kind_out,
  output logic [ADDR_W-1:0] bus_cyc_addr_out,
  output logic [csh_pkg::VEC_W-1:0] irq_vector_out,
  output logic irq_dispatch_out,
  output logic pipeline_flush_out,
  output logic fetch_redirect_out,
  output logic [31:0] fetch_addr_out,
  output logic arch_state_init_out,
  output logic cache_fp_reset_out,
  output logic fp_error_report_out,
  output logic fp_error_ignored_out
);
  import csh_pkg::*;

  if (LINE_LSB < 3 || LINE_LSB >= ADDR_W || ADDR_W != 32) begin : g_param_check
    $error("csh_sys_ctrl: unsupported address or line width");
  end

  csh_st_t st_r;
  csh_st_t st_nxt;
  logic hold_pending;
  logic bus_float;
  logic wb_req;
  logic wb_done;
  logic cycle_active;
  logic flush_pend_r;
  logic in_rst_r;
  logic init_prev_r;
  logic init_rise;
  logic irq_ok;

  csh_snoop_unit #(
    .ADDR_W(ADDR_W),
    .LINE_LSB(LINE_LSB)
  ) u_snoop (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .snoop_addr_strobe_n_in(snoop_addr_strobe_n_in), // see R14
    .snoop_addr_in(snoop_addr_in),
    .snoop_invalidate_in(snoop_invalidate_in),
    .probe_hit_in(probe_hit_in),
    .probe_modified_in(probe_modified_in),
    .wb_done_in(wb_done),
    .probe_req_out(probe_req_out),
    .probe_addr_out(probe_addr_out),
    .line_update_out(line_update_out),
    .line_update_state_out(line_update_state_out),
    .snoop_hit_n_out(snoop_hit_n_out),
    .snoop_hit_modified_n_out(snoop_hit_modified_n_out),
    .wb_req_out(wb_req)
  );

  csh_hold_arb u_hold (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .bus_hold_req_in(bus_hold_req_in), // see R6
    .cycle_active_in(cycle_active),
    .hold_pending_out(hold_pending),
    .bus_float_out(bus_float),
    .bus_hold_ack_out(bus_hold_ack_out)
  );

  // Any sequence in flight, or the core's own cycles, keeps the bus owned
  assign cycle_active = (st_r != ST_IDLE) || core_bus_busy_in;
  assign bus_drive_en_out = !bus_float && !tristate_test_mode_out; // see R8
  assign wb_done = (st_r == ST_WB) && bus_cyc_done_in;
  assign init_rise = soft_init_in && !init_prev_r;
  assign irq_ok = maskable_irq_in && irq_enable_in && !init_rise; // see R13

  // Strap capture on the first edge after reset release
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      in_rst_r <= 1'h1;
      tristate_test_mode_out <= TRISTATE_RST;
    end else begin
      in_rst_r <= 1'h0;
      if (in_rst_r) begin
        tristate_test_mode_out <= !flush_req_n_in; // see R2
      end
    end
  end

  // Set wins over the clear taken when the flush sequence starts
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      flush_pend_r <= 1'h0;
    end else if (!flush_req_n_in && !in_rst_r) begin
      flush_pend_r <= 1'h1; // see R1
    end else if (st_nxt == ST_FLUSH_CACHE && st_r == ST_IDLE) begin
      flush_pend_r <= 1'h0;
    end
  end

  // New sequences wait while hold is pending; writeback owed to a snoop goes first
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE: begin
        if (hold_pending || core_bus_busy_in) begin
          st_nxt = ST_IDLE; // see R7
        end else if (wb_req) begin
          st_nxt = ST_WB; // see R5
        end else if (flush_pend_r) begin
          st_nxt = ST_FLUSH_CACHE; // see R1
        end else if (irq_ok) begin
          st_nxt = ST_INTA1; // see R12
        end
      end
      ST_FLUSH_CACHE: if (cache_flush_done_in) st_nxt = ST_FLUSH_CYC; // see R1
      ST_FLUSH_CYC: if (bus_cyc_done_in) st_nxt = ST_IDLE;
      ST_INTA1: if (bus_cyc_done_in) st_nxt = ST_INTA2; // see R12
      ST_INTA2: if (bus_cyc_done_in) st_nxt = ST_IDLE;
      ST_WB: if (bus_cyc_done_in) st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_r <= ST_IDLE;
    end else if (init_rise) begin
      st_r <= (st_r == ST_WB) ? st_r : ST_IDLE; // see R11
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cache_flush_start_out <= 1'h0;
    end else begin
      cache_flush_start_out <= (st_r == ST_IDLE) && (st_nxt == ST_FLUSH_CACHE) && !init_rise; // see R1
    end
  end

  // Bus cycle request stands until the core reports the cycle done, or until a soft init edge arrives outside a writeback
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      bus_cyc_req_out <= 1'h0;
      bus_cyc_kind_out <= CYC_FLUSH_ACK;
      bus_cyc_addr_out <= '0;
    end else begin
      bus_cyc_req_out <= 1'h0;
      if (!init_rise || st_r == ST_WB) begin
        unique case (st_nxt)
          ST_FLUSH_CYC: begin
            bus_cyc_req_out <= !(st_r == ST_FLUSH_CYC && bus_cyc_done_in);
            bus_cyc_kind_out <= CYC_FLUSH_ACK; // see R1
          end
          ST_INTA1, ST_INTA2: begin
            bus_cyc_req_out <= !(st_nxt == st_r && bus_cyc_done_in) && !(st_r == ST_INTA1 && bus_cyc_done_in);
            bus_cyc_kind_out <= CYC_INTA; // see R12
          end
          ST_WB: begin
            bus_cyc_req_out <= 1'h1;
            bus_cyc_kind_out <= CYC_WRITEBACK; // see R5
            bus_cyc_addr_out <= {probe_addr_out, {LINE_LSB{1'b0}}};
          end
          default: bus_cyc_req_out <= 1'h0;
        endcase
      end
    end
  end

  // Vector comes from the second acknowledge cycle
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      irq_vector_out <= '0;
      irq_dispatch_out <= 1'h0;
    end else begin
      irq_dispatch_out <= (st_r == ST_INTA2) && bus_cyc_done_in && !init_rise;
      if (st_r == ST_INTA2 && bus_cyc_done_in) begin
        irq_vector_out <= bus_cyc_data_in; // see R12
      end
    end
  end

  // Soft init redirects fetch; cache and floating-point state reset only on hard reset
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      init_prev_r <= 1'h0;
      pipeline_flush_out <= 1'h1;
      fetch_redirect_out <= 1'h1;
      fetch_addr_out <= RESET_VECTOR;
      arch_state_init_out <= 1'h1;
      cache_fp_reset_out <= 1'h1;
    end else begin
      init_prev_r <= soft_init_in;
      pipeline_flush_out <= init_rise; // see R10
      fetch_redirect_out <= init_rise;
      fetch_addr_out <= RESET_VECTOR; // see R10
      arch_state_init_out <= init_rise;
      cache_fp_reset_out <= 1'h0; // see R11
    end
  end

  // Native error mode takes precedence: the ignore input only acts outside it
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      fp_error_report_out <= 1'h0;
      fp_error_ignored_out <= 1'h0;
    end else begin
      fp_error_ignored_out <= fp_exception_in && !ignore_fp_error_n_in && !fp_native_mode_in; // see R9
      fp_error_report_out <= fp_exception_in && (ignore_fp_error_n_in || fp_native_mode_in);
    end
  end

  a_flush_ack_cycle: assert property (@(posedge clk_in) disable iff (sys_rst_in || soft_init_in) // see R1
    (st_r == ST_FLUSH_CACHE && cache_flush_done_in) |=> (bus_cyc_req_out && bus_cyc_kind_out == CYC_FLUSH_ACK))
    else $error("flush acknowledge cycle not issued after cache flush");
  a_strap_capture: assert property (@(posedge clk_in) // see R2
    $fell(sys_rst_in) |=> (tristate_test_mode_out == !$past(flush_req_n_in)))
    else $error("tri-state test strap not captured at reset release");
  a_no_start_in_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see R7
    (st_r == ST_IDLE && hold_pending) |=> (st_r == ST_IDLE))
    else $error("bus sequence started while hold pending");
  a_float_in_ack: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see R8
    bus_hold_ack_out |-> !bus_drive_en_out)
    else $error("bus driven during hold acknowledge");
  a_irq_masked: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see R13
    (st_r == ST_IDLE && !irq_enable_in && !wb_req && !flush_pend_r) |=> (st_r != ST_INTA1))
    else $error("interrupt acknowledged while masked");
  a_inta_pair: assert property (@(posedge clk_in) disable iff (sys_rst_in || soft_init_in) // see R12
    (st_r == ST_INTA1 && bus_cyc_done_in) |=> (st_r == ST_INTA2) ##0 (bus_cyc_kind_out == CYC_INTA))
    else $error("second interrupt acknowledge cycle missing");
  a_init_vector: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see R10
    init_rise |=> (pipeline_flush_out && fetch_redirect_out && fetch_addr_out == RESET_VECTOR && !cache_fp_reset_out))
    else $error("soft init did not redirect to reset vector");
  a_fp_ignore: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see R9
    (fp_exception_in && !ignore_fp_error_n_in && !fp_native_mode_in) |=> (fp_error_ignored_out && !fp_error_report_out))
    else $error("floating-point exception not ignored");
endmodule

// >>> tb/csh_bus_partner.sv
`timescale 1ns/1ns
module csh_bus_partner #(
  parameter int LAT = 3,
  parameter logic [7:0] VEC = 8'h5A
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic slow_in,
  input wire logic probe_req_in,
  input wire logic [31:5] probe_addr_in,
  input wire logic [31:5] line_addr_in,
  input wire logic line_valid_in,
  input wire logic line_dirty_in,
  input wire logic cache_flush_start_in,
  input wire logic bus_cyc_req_in,
  output logic probe_hit_out,
  output logic probe_modified_out,
  output logic cache_flush_done_out,
  output logic bus_cyc_done_out,
  output logic [7:0] bus_cyc_data_out
);
  logic [3:0] cnt_r;
  logic [2:0] fl_r;
  // One cached line; tag answer is combinational in the probe cycle
  assign probe_hit_out = probe_req_in && line_valid_in && (probe_addr_in == line_addr_in);
  assign probe_modified_out = probe_hit_out && line_dirty_in;
  // Vector only meaningful with done; a moving pattern otherwise so stale data cannot pass
  assign bus_cyc_data_out = bus_cyc_done_out ? VEC : (~VEC ^ {4'h0, cnt_r});
  assign cache_flush_done_out = fl_r[2];
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cnt_r <= 4'h0;
      bus_cyc_done_out <= 1'b0;
    end else if (bus_cyc_req_in && !bus_cyc_done_out) begin
      cnt_r <= cnt_r + 4'h1;
      bus_cyc_done_out <= (cnt_r == (slow_in ? 4'(LAT) : 4'h0));
    end else begin
      cnt_r <= 4'h0;
      bus_cyc_done_out <= 1'b0;
    end
  end
  always_ff @(posedge clk_in) begin
    fl_r <= sys_rst_in ? 3'h0 : {fl_r[1:0], cache_flush_start_in};
  end
endmodule

// >>> tb/test_csh_sys_ctrl.sv
`timescale 1ns/1ns
module test_csh_sys_ctrl import csh_pkg::*;;
  localparam logic [7:0] VEC = 8'h5A;
  localparam logic [31:5] LINE = 27'h0ABCDEF;
  logic clk_in = 0, sys_rst_in = 1, flush_req_n = 0, strobe_n = 1, snoop_invalidate = 0, hold_req = 0, ign_n = 1;
  logic soft_init = 0, irq = 0, busy = 0, irq_en = 0, fp_exc = 0, fp_nat = 0, slow = 0;
  logic line_valid = 1, line_dirty = 0;
  logic [31:5] snoop_addr = '0;
  logic p_hit, p_mod, fl_done, cyc_done, probe_req, line_upd, flush_start, cyc_req, dispatch;
  logic hit_n, snoop_hit_modified_n_n, ack, drive_en, tri_mode, pipe_flush, redirect, st_init, cfp_reset, fp_rep, fp_ign;
  logic [7:0] cyc_data, vector;
  logic [31:5] probe_addr;
  logic [31:0] cyc_addr, fetch_addr;
  csh_line_upd_t upd_state;
  csh_cyc_t kind;
  int fail_count = 0;
  int n_tests = 0;

  csh_sys_ctrl #(.ADDR_W(32), .LINE_LSB(5)) dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .flush_req_n_in(flush_req_n), .snoop_addr_strobe_n_in(strobe_n), .snoop_addr_in(snoop_addr),
    .snoop_invalidate_in(snoop_invalidate), .bus_hold_req_in(hold_req), .ignore_fp_error_n_in(ign_n),
    .soft_init_in(soft_init), .maskable_irq_in(irq), .core_bus_busy_in(busy), .irq_enable_in(irq_en),
    .fp_exception_in(fp_exc), .fp_native_mode_in(fp_nat), .probe_hit_in(p_hit), .probe_modified_in(p_mod),
    .cache_flush_done_in(fl_done), .bus_cyc_done_in(cyc_done), .bus_cyc_data_in(cyc_data),
    .snoop_hit_n_out(hit_n), .snoop_hit_modified_n_out(snoop_hit_modified_n_n), .bus_hold_ack_out(ack),
    .bus_drive_en_out(drive_en), .tristate_test_mode_out(tri_mode), .probe_req_out(probe_req),
    .probe_addr_out(probe_addr), .line_update_out(line_upd), .line_update_state_out(upd_state),
    .cache_flush_start_out(flush_start), .bus_cyc_req_out(cyc_req), .bus_cyc_kind_out(kind),
    .bus_cyc_addr_out(cyc_addr), .irq_vector_out(vector), .irq_dispatch_out(dispatch),
    .pipeline_flush_out(pipe_flush), .fetch_redirect_out(redirect), .fetch_addr_out(fetch_addr),
    .arch_state_init_out(st_init), .cache_fp_reset_out(cfp_reset), .fp_error_report_out(fp_rep),
    .fp_error_ignored_out(fp_ign));

  csh_bus_partner #(.LAT(3), .VEC(VEC)) partner (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .slow_in(slow),
    .probe_req_in(probe_req), .probe_addr_in(probe_addr), .line_addr_in(LINE), .line_valid_in(line_valid),
    .line_dirty_in(line_dirty), .cache_flush_start_in(flush_start), .bus_cyc_req_in(cyc_req),
    .probe_hit_out(p_hit), .probe_modified_out(p_mod), .cache_flush_done_out(fl_done),
    .bus_cyc_done_out(cyc_done), .bus_cyc_data_out(cyc_data));

  initial begin
    forever #10 clk_in = ~clk_in;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: pick = probe_req;
      1: pick = cyc_req;
      2: pick = flush_start;
      3: pick = dispatch;
      4: pick = !drive_en;
      default: pick = pipe_flush;
    endcase
  endfunction

  // Bounded wait; the design's own completion signal ends it
  task automatic wait_for(input int s, input string name);
    int n;
    n = 0;
    while (pick(s) !== 1'b1 && n < 40) begin
      step(1);
      n++;
    end
    chk(name, 1, pick(s));
  endtask

  task automatic wait_cyc(input csh_cyc_t k, input logic [31:0] a);
    int n;
    n = 0;
    wait_for(1, "bus cycle request");
    chk("bus cycle kind", k, kind);
    if (k == CYC_WRITEBACK) chk("writeback address", a, cyc_addr);
    while (cyc_req === 1'b1 && n < 40) begin
      step(1);
      n++;
    end
    chk("bus cycle end", 0, cyc_req);
  endtask

  task automatic hard_reset(input logic fl_n);
    sys_rst_in = 1;
    flush_req_n = fl_n;
    step(12);
    chk("cache reset in hard reset", 1, cfp_reset);
    sys_rst_in = 0;
    step(1);
    flush_req_n = 1;
    chk("tristate mode", !fl_n, tri_mode);
    chk("hit idle", 1, hit_n);
    chk("snoop_hit_modified_n idle", 1, snoop_hit_modified_n_n);
    chk("hold ack idle", 0, ack);
    chk("bus driven", fl_n, drive_en);
    $display("test hard_reset done");
  endtask

  task automatic snoop(input logic [31:5] a, input logic iv, input logic h, input logic m);
    strobe_n = 0;
    snoop_addr = a;
    snoop_invalidate = iv;
    step(1);
    strobe_n = 1;
    snoop_addr = ~a;
    wait_for(0, "probe request");
    chk("probe address", a, probe_addr);
    step(1);
    chk("snoop hit", !h, hit_n);
    chk("snoop hit modified", !m, snoop_hit_modified_n_n);
    if (h) chk("line update", 1, line_upd);
    if (h) chk("line update state", iv, upd_state);
    step(2);
  endtask

  task automatic t_snoop;
    snoop(LINE ^ 27'h1, 1, 0, 0);
    snoop(LINE, 1, 1, 0);
    line_dirty = 1;
    slow = 1;
    snoop(LINE, 0, 1, 1);
    line_dirty = 0;
    wait_cyc(CYC_WRITEBACK, {LINE, 5'h00});
    step(1);
    chk("snoop_hit_modified_n after writeback", 1, snoop_hit_modified_n_n);
    slow = 0;
    $display("test t_snoop done");
  endtask

  task automatic t_hold_flush;
    busy = 1;
    hold_req = 1;
    step(5);
    chk("ack while busy", 0, ack);
    chk("driven while busy", 1, drive_en);
    busy = 0;
    wait_for(4, "bus float");
    chk("float before ack", 0, ack);
    step(1);
    chk("hold ack", 1, ack);
    flush_req_n = 0;
    step(1);
    flush_req_n = 1;
    step(3);
    chk("ack stands", 1, ack);
    chk("bus floated", 0, drive_en);
    chk("no flush while held", 0, cyc_req);
    hold_req = 0;
    step(2);
    chk("ack dropped", 0, ack);
    chk("bus resumed", 1, drive_en);
    wait_for(2, "flush start");
    wait_cyc(CYC_FLUSH_ACK, 32'h0);
    $display("test t_hold_flush done");
  endtask

  task automatic t_irq;
    int n;
    int dones;
    int bad;
    n = 0;
    dones = 0;
    bad = 0;
    irq = 1;
    step(8);
    chk("masked irq", 0, cyc_req);
    irq_en = 1;
    while (dones < 2 && n < 60) begin
      step(1);
      n++;
      if (cyc_req === 1'b1) irq = 0;
      if (cyc_req === 1'b1 && kind !== CYC_INTA) bad++;
      if (cyc_done === 1'b1) dones++;
    end
    chk("inta cycles", 2, dones);
    chk("inta kind", 0, bad);
    wait_for(3, "irq dispatch");
    chk("irq vector", VEC, vector);
    irq_en = 0;
    $display("test t_irq done");
  endtask

  task automatic t_init;
    soft_init = 1;
    wait_for(5, "pipeline flush");
    chk("fetch redirect", 1, redirect);
    chk("state init", 1, st_init);
    chk("fetch address", RESET_VECTOR, fetch_addr);
    chk("caches kept", 0, cfp_reset);
    soft_init = 0;
    step(2);
    chk("pipeline flush ends", 0, pipe_flush);
    $display("test t_init done");
  endtask

  task automatic t_fp;
    logic e;
    fp_exc = 1;
    for (int i = 0; i < 4; i++) begin
      ign_n = i[0];
      fp_nat = i[1];
      e = !ign_n && !fp_nat;
      step(2);
      chk("fp ignored", e, fp_ign);
      chk("fp reported", !e, fp_rep);
    end
    fp_exc = 0;
    step(2);
    chk("fp quiet", 0, fp_ign | fp_rep);
    $display("test t_fp done");
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // About 100 cycles of tests; the limit leaves wide margin
  initial begin
    #100000;
    fail_count++;
    $display("[FAIL] watchdog expected done seen timeout");
    report_and_stop;
  end

  initial begin
    hard_reset(0);
    hard_reset(1);
    t_snoop;
    t_hold_flush;
    t_irq;
    t_init;
    t_fp;
    report_and_stop;
  end
endmodule
